// ### t1_irq_map.svh
`ifndef T1_IRQ_MAP_SVH
`define T1_IRQ_MAP_SVH

// ----------------------------------------------------------------
// Register offsets within one framer (low address byte)
// ----------------------------------------------------------------
`define CS_STATUS_OFS     8'h34
`define CS_STATUS_ALT_OFS 8'h24
`define AL_STATUS_OFS     8'h35
`define AL_STATUS_ALT_OFS 8'h25
`define CS_MASK_OFS       8'h44
`define AL_MASK_OFS       8'h45

// ----------------------------------------------------------------
// Framer select field
// ----------------------------------------------------------------
`define SEL_MSB           11
`define SEL_LSB           8
`define BCAST_SEL         4'h8

// ----------------------------------------------------------------
// Reset values and implemented bits
// ----------------------------------------------------------------
`define FLAG_RESET        16'h0000
`define MASK_RESET        16'h0000
`define AL_USED           16'hF800
`define CNT_MAX           8'hFF
`define CNT_ZERO          8'h00

// ----------------------------------------------------------------
// Counter/sync status bit positions
// ----------------------------------------------------------------
`define CS_WRAP_TOP       15
`define CS_TSYNC          7
`define CS_MFSYNC         6
`define CS_FBE            5
`define CS_ALIGN          4
`define CS_SEF            3
`define CS_AIS            2
`define CS_CRC            1
`define CS_LOS            0

// ----------------------------------------------------------------
// Alarm status bit positions
// ----------------------------------------------------------------
`define AL_SF_YEL         15
`define AL_SF_PERSIST     14
`define AL_SEC_YEL        13
`define AL_ESF_YEL        12
`define AL_DM_YEL         11

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define CLK_PERIOD_NS     25
`define MS_NS             1000000
`define YEL_PERSIST_MS    48
`define SEF_WINDOW        6
`define SEF_ERRORS        2

`endif

// ### t1_irq_pkg.sv
`default_nettype none
package t1_irq_pkg;

  typedef enum logic [2:0] {
    REG_NONE,
    REG_CS_STATUS,
    REG_AL_STATUS,
    REG_CS_MASK,
    REG_AL_MASK
  } regSel_t;

  typedef enum logic [1:0] {
    PERSIST_IDLE,
    PERSIST_COUNT,
    PERSIST_HELD
  } persistState_t;

endpackage : t1_irq_pkg
`default_nettype wire

// ### yellow_persist.sv
`timescale 1ns/1ps
`default_nettype none
`include "t1_irq_map.svh"

module yellow_persist
  import t1_irq_pkg::*;
#(
  parameter int TICKS = `YEL_PERSIST_MS
) (
  input  wire logic clk,      // System clock
  input  wire logic reset_n,  // Synchronous reset
  input  wire logic clear,    // Soft reset
  input  wire logic tick,     // One pulse per millisecond
  input  wire logic yellow,   // Superframe yellow code present
  output logic      reached   // Pulse when held long enough
);

  localparam int CW = $clog2(TICKS + 1);

  persistState_t  state;
  logic [CW-1:0]  msCnt;

  generate
    if (TICKS < 1) begin : g_chk
      $error("yellow_persist: TICKS must be at least 1");
    end
  endgenerate

  // ----------------------------------------------------------------
  // Persistence count, restarted whenever the code drops
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    reached <= 1'b0;
    if (!reset_n || clear || !yellow) begin
      state <= PERSIST_IDLE;
      msCnt <= '0;
    end else begin
      case (state)
        PERSIST_IDLE: begin
          state <= PERSIST_COUNT;
          msCnt <= '0;
        end
        PERSIST_COUNT: begin
          if (tick) begin
            if (msCnt == CW'(TICKS - 1)) begin
              reached <= 1'b1;
              state   <= PERSIST_HELD;
            end
            msCnt <= msCnt + CW'(1);
          end
        end
        PERSIST_HELD: state <= PERSIST_HELD;
        default:      state <= PERSIST_IDLE;
      endcase
    end
  end

  property p_persist_needs_code;
    @(posedge clk) disable iff (!reset_n)
      reached |-> $past(yellow) && $past(state) == PERSIST_COUNT;
  endproperty
  a_persist_needs_code: assert property (p_persist_needs_code)
    else $error("persistence pulse without held yellow code");

endmodule : yellow_persist
`default_nettype wire

// ### sync_alarm_irq_status.sv
`timescale 1ns/1ps
`default_nettype none
`include "t1_irq_map.svh"

module sync_alarm_irq_status
  import t1_irq_pkg::*;
#(
  parameter int NF          = 8,
  parameter int TICK_CYCLES = `MS_NS / `CLK_PERIOD_NS
) (
  input  wire logic            clk,                 // 40 MHz clock
  input  wire logic            reset_n,             // Sync reset
  input  wire logic            softReset,           // Soft reset
  input  wire logic [11:0]     hostAddr,            // Host address
  input  wire logic            hostRead,            // Read strobe
  input  wire logic            hostWrite,           // Write strobe
  input  wire logic [15:0]     hostWrData,          // Write data
  output logic      [15:0]     hostRdData,          // Read data
  output logic                 irq,                 // Interrupt request
  input  wire logic [NF*8-1:0] frameBitErrCnt,      // Counters, 8b each
  input  wire logic [NF*8-1:0] crc6ErrCnt,          // Counters
  input  wire logic [NF*8-1:0] outOfFrameCnt,       // Counters
  input  wire logic [NF*8-1:0] alignChangeCnt,      // Counters
  input  wire logic [NF*8-1:0] bipolarViolCnt,      // Counters
  input  wire logic [NF*8-1:0] testPatternErrCnt,   // Counters
  input  wire logic [NF*8-1:0] testPatternMfCnt,    // Counters
  input  wire logic [NF*8-1:0] mfOutOfSyncCnt,      // Counters
  input  wire logic [NF-1:0]   terminalSync,        // Frame sync level
  input  wire logic [NF-1:0]   multiframeSync,      // MF sync level
  input  wire logic [NF-1:0]   framingBitTick,      // Framing bit seen
  input  wire logic [NF-1:0]   framingBitError,     // Framing bit wrong
  input  wire logic [NF-1:0]   alignmentChange,     // New alignment
  input  wire logic [NF-1:0]   allOnesAlarm,        // AIS level
  input  wire logic [NF-1:0]   crc6Error,           // CRC-6 mismatch
  input  wire logic [NF-1:0]   signalLoss,          // Loss of signal
  input  wire logic [NF-1:0]   superframeYellow,    // SF yellow level
  input  wire logic [NF-1:0]   secondaryYellow,     // Secondary yellow
  input  wire logic [NF-1:0]   extSuperframeYellow, // EXTENDED_SUPERFRAME_FORMAT yellow
  input  wire logic [NF-1:0]   dataModeYellow       // Data mode yellow
);

  localparam int TW = $clog2(TICK_CYCLES + 1);
  localparam int SW = `SEL_MSB - `SEL_LSB + 1;

  logic [15:0] csFlag [NF];
  logic [15:0] alFlag [NF];
  logic [15:0] csMask [NF];
  logic [15:0] alMask [NF];
  logic [NF-1:0] persistHit;
  logic [TW-1:0] tickCnt;
  logic          msTick;
  logic [15:0]   next_rdData;
  logic          next_irq;
  logic [SW-1:0] hostSel;
  regSel_t       hostReg;

  generate
    if (NF < 1 || NF > 8 || TICK_CYCLES < 1) begin : g_chk
      $error("sync_alarm_irq_status: NF 1 to 8, TICK_CYCLES 1 or more");
    end
  endgenerate

  // ----------------------------------------------------------------
  // Decoding
  // ----------------------------------------------------------------
  function automatic regSel_t decodeReg(input logic [7:0] ofs);
    case (ofs)
      `CS_STATUS_OFS, `CS_STATUS_ALT_OFS: decodeReg = REG_CS_STATUS;
      `AL_STATUS_OFS, `AL_STATUS_ALT_OFS: decodeReg = REG_AL_STATUS;
      `CS_MASK_OFS:                       decodeReg = REG_CS_MASK;
      `AL_MASK_OFS:                       decodeReg = REG_AL_MASK;
      default:                            decodeReg = REG_NONE;
    endcase
  endfunction : decodeReg

  function automatic logic wrapped(input logic [7:0] prev, cur);
    wrapped = (prev == `CNT_MAX) && (cur == `CNT_ZERO);
  endfunction : wrapped

  assign hostSel = hostAddr[`SEL_MSB:`SEL_LSB];
  assign hostReg = decodeReg(hostAddr[7:0]);

  // ----------------------------------------------------------------
  // Millisecond enable for the yellow persistence timers
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    msTick <= 1'b0;
    if (!reset_n || softReset) begin
      tickCnt <= '0;
    end else if (tickCnt == TW'(TICK_CYCLES - 1)) begin
      tickCnt <= '0;
      msTick  <= 1'b1;
    end else begin
      tickCnt <= tickCnt + TW'(1);
    end
  end

  // ----------------------------------------------------------------
  // Per-framer flag logic
  // ----------------------------------------------------------------
  for (genvar i = 0; i < NF; i++) begin : g_fr
    logic [7:0]  curCnt  [8];
    logic [7:0]  prevCnt [8];
    logic [15:0] csEvt;
    logic [15:0] alEvt;
    logic        prevTSync;
    logic        prevMfSync;
    logic [`SEF_WINDOW-2:0] errHist;
    logic        sefHit;
    logic        mine, writeMe, csClr, alClr;

    assign curCnt[0] = frameBitErrCnt[i*8 +: 8];
    assign curCnt[1] = crc6ErrCnt[i*8 +: 8];
    assign curCnt[2] = outOfFrameCnt[i*8 +: 8];
    assign curCnt[3] = alignChangeCnt[i*8 +: 8];
    assign curCnt[4] = bipolarViolCnt[i*8 +: 8];
    assign curCnt[5] = testPatternErrCnt[i*8 +: 8];
    assign curCnt[6] = testPatternMfCnt[i*8 +: 8];
    assign curCnt[7] = mfOutOfSyncCnt[i*8 +: 8];

    // Counter wrap events, counters in bit order 15 down to 8
    for (genvar k = 0; k < 8; k++) begin : g_cnt
      always_ff @(posedge clk) begin
        if (!reset_n || softReset) begin
          prevCnt[k] <= `CNT_ZERO;
        end else begin
          prevCnt[k] <= curCnt[k];
        end
      end
      assign csEvt[`CS_WRAP_TOP-k] = wrapped(prevCnt[k], curCnt[k]);
    end

    always_ff @(posedge clk) begin
      if (!reset_n || softReset) begin
        prevTSync  <= 1'b0;
        prevMfSync <= 1'b0;
      end else begin
        prevTSync  <= terminalSync[i];
        prevMfSync <= multiframeSync[i];
      end
    end

    // History of the last framing bits for the two-in-six test
    always_ff @(posedge clk) begin
      if (!reset_n || softReset) begin
        errHist <= '0;
      end else if (framingBitTick[i]) begin
        errHist <= {errHist[`SEF_WINDOW-3:0], framingBitError[i]};
      end
    end

    assign sefHit = framingBitTick[i] && framingBitError[i] &&
                    ($countones(errHist) >= `SEF_ERRORS - 1);

    assign csEvt[`CS_TSYNC]  = terminalSync[i] ^ prevTSync;
    assign csEvt[`CS_MFSYNC] = multiframeSync[i] ^ prevMfSync;
    assign csEvt[`CS_FBE]    = framingBitError[i] &&
                               terminalSync[i];
    assign csEvt[`CS_ALIGN]  = alignmentChange[i];
    assign csEvt[`CS_SEF]    = sefHit;
    assign csEvt[`CS_AIS]    = allOnesAlarm[i];
    assign csEvt[`CS_CRC]    = crc6Error[i];
    assign csEvt[`CS_LOS]    = signalLoss[i];

    always_comb begin
      alEvt                 = '0;
      alEvt[`AL_SF_YEL]     = superframeYellow[i];
      alEvt[`AL_SF_PERSIST] = persistHit[i];
      alEvt[`AL_SEC_YEL]    = secondaryYellow[i];
      alEvt[`AL_ESF_YEL]    = extSuperframeYellow[i];
      alEvt[`AL_DM_YEL]     = dataModeYellow[i];
    end

    yellow_persist #(.TICKS(`YEL_PERSIST_MS)) u_persist (
      .clk     (clk),
      .reset_n (reset_n),
      .clear   (softReset),
      .tick    (msTick),
      .yellow  (superframeYellow[i]),
      .reached (persistHit[i])
    );

    assign mine    = (hostSel == SW'(i));
    assign writeMe = hostWrite && (mine || hostSel == `BCAST_SEL);
    assign csClr   = hostRead && mine && hostReg == REG_CS_STATUS;
    assign alClr   = hostRead && mine && hostReg == REG_AL_STATUS;

    // Mask registers, 1 enables a flag
    always_ff @(posedge clk) begin
      if (!reset_n || softReset) begin
        csMask[i] <= `MASK_RESET;
        alMask[i] <= `MASK_RESET;
      end else if (writeMe && hostReg == REG_CS_MASK) begin
        csMask[i] <= hostWrData;
      end else if (writeMe && hostReg == REG_AL_MASK) begin
        alMask[i] <= hostWrData & `AL_USED;
      end
    end

    // Sticky flags; a new event wins over the read clear
    always_ff @(posedge clk) begin
      if (!reset_n || softReset) begin
        csFlag[i] <= `FLAG_RESET;
        alFlag[i] <= `FLAG_RESET;
      end else begin
        csFlag[i] <= (csFlag[i] & ~{16{csClr}}) |
                     (csEvt & csMask[i]);
        alFlag[i] <= ((alFlag[i] & ~{16{alClr}}) |
                      (alEvt & alMask[i])) & `AL_USED;
      end
    end

    property p_wrap_sets;
      @(posedge clk) disable iff (!reset_n || softReset)
        wrapped(prevCnt[0], curCnt[0]) && csMask[i][`CS_WRAP_TOP]
        |=> csFlag[i][`CS_WRAP_TOP];
    endproperty
    a_wrap_sets: assert property (p_wrap_sets)
      else $error("counter wrap did not set flag");
    property p_crc_wrap;
      @(posedge clk) disable iff (!reset_n || softReset)
        !csMask[i][`CS_WRAP_TOP-1] |=> !$rose(csFlag[i][`CS_WRAP_TOP-1]);
    endproperty
    a_crc_wrap: assert property (p_crc_wrap)
      else $error("masked flag was set");
    property p_sync_change;
      @(posedge clk) disable iff (!reset_n || softReset)
        csMask[i][`CS_TSYNC] && $changed(terminalSync[i])
        |-> ##1 csFlag[i][`CS_TSYNC];
    endproperty
    a_sync_change: assert property (p_sync_change)
      else $error("sync change not flagged");
    property p_fbe_needs_sync;
      @(posedge clk) disable iff (!reset_n || softReset)
        csMask[i][`CS_FBE] && !terminalSync[i] && !csFlag[i][`CS_FBE]
        |=> !csFlag[i][`CS_FBE];
    endproperty
    a_fbe_needs_sync: assert property (p_fbe_needs_sync)
      else $error("framing error flagged out of sync");
    property p_sef;
      @(posedge clk) disable iff (!reset_n || softReset)
        sefHit && csMask[i][`CS_SEF] |=> csFlag[i][`CS_SEF];
    endproperty
    a_sef: assert property (p_sef)
      else $error("severe errored frame not flagged");
    property p_los;
      @(posedge clk) disable iff (!reset_n || softReset)
        signalLoss[i] && csMask[i][`CS_LOS] |=> csFlag[i][`CS_LOS];
    endproperty
    a_los: assert property (p_los)
      else $error("loss of signal not flagged");
    property p_cs_clear;
      @(posedge clk) disable iff (!reset_n || softReset)
        csClr && ((csEvt & csMask[i]) == 16'h0000) |=> csFlag[i] == 16'h0000;
    endproperty
    a_cs_clear: assert property (p_cs_clear)
      else $error("read did not clear counter/sync flags");
    property p_al_clear;
      @(posedge clk) disable iff (!reset_n || softReset)
        alClr && ((alEvt & alMask[i]) == 16'h0000) |=> alFlag[i] == 16'h0000;
    endproperty
    a_al_clear: assert property (p_al_clear)
      else $error("read did not clear alarm flags");
    property p_sf_yellow;
      @(posedge clk) disable iff (!reset_n || softReset)
        superframeYellow[i] && alMask[i][`AL_SF_YEL]
        |=> alFlag[i][`AL_SF_YEL];
    endproperty
    a_sf_yellow: assert property (p_sf_yellow)
      else $error("superframe yellow not flagged");
    property p_persist_flag;
      @(posedge clk) disable iff (!reset_n || softReset)
        persistHit[i] && alMask[i][`AL_SF_PERSIST]
        |=> alFlag[i][`AL_SF_PERSIST];
    endproperty
    a_persist_flag: assert property (p_persist_flag)
      else $error("persistent yellow not flagged");
    property p_unused_zero;
      @(posedge clk) disable iff (!reset_n)
        (alFlag[i] & ~`AL_USED) == 16'h0000 &&
        (alMask[i] & ~`AL_USED) == 16'h0000;
    endproperty
    a_unused_zero: assert property (p_unused_zero)
      else $error("unused alarm bit not zero");
    property p_bcast;
      @(posedge clk) disable iff (!reset_n || softReset)
        hostWrite && hostSel == `BCAST_SEL && hostReg == REG_CS_MASK
        |=> csMask[i] == $past(hostWrData);
    endproperty
    a_bcast: assert property (p_bcast)
      else $error("broadcast write missed a framer");
  end

  // ----------------------------------------------------------------
  // Read data and interrupt request
  // ----------------------------------------------------------------
  always_comb begin
    next_rdData = '0;
    next_irq    = 1'b0;
    for (int j = 0; j < NF; j++) begin
      next_irq = next_irq || ((csFlag[j] & csMask[j]) != 16'h0000) ||
                 ((alFlag[j] & alMask[j]) != 16'h0000);
      if (hostSel == SW'(j)) begin
        case (hostReg)
          REG_CS_STATUS: next_rdData = csFlag[j];
          REG_AL_STATUS: next_rdData = alFlag[j];
          REG_CS_MASK:   next_rdData = csMask[j];
          REG_AL_MASK:   next_rdData = alMask[j];
          default:       next_rdData = '0;
        endcase
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n || softReset) begin
      hostRdData <= '0;
    end else if (hostRead) begin
      hostRdData <= next_rdData;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n || softReset) begin
      irq <= 1'b0;
    end else begin
      irq <= next_irq;
    end
  end

  property p_irq;
    @(posedge clk) disable iff (!reset_n || softReset)
      (csFlag[0] & csMask[0]) != 16'h0000 |=> irq;
  endproperty
  a_irq: assert property (p_irq)
    else $error("interrupt request does not follow flags");

endmodule : sync_alarm_irq_status
`default_nettype wire

// ### t1_sync_alarm_irq_status_bench.sv
`timescale 1ns/1ps
`default_nettype none

module t1_sync_alarm_irq_status_bench import t1_irq_pkg::*;;
  logic        clk        = 1'b0;
  logic        reset_n    = 1'b0;
  logic        softReset  = 1'b0;
  logic [11:0] hostAddr   = 12'h000;
  logic        hostRead   = 1'b0;
  logic        hostWrite  = 1'b0;
  logic [15:0] hostWrData = 16'h0000;
  logic [15:0] hostRdData;
  logic        irq;
  logic [15:0] cnt [8]    = '{default: 16'h0000};
  logic [1:0]  ev [12]    = '{default: 2'h0};
  int          mismatches = 0;
  int          compares   = 0;

  // ------------------------------------------------------------
  // Clock and design
  // ------------------------------------------------------------
  always #12.5 clk = ~clk;

  sync_alarm_irq_status #(.NF(2), .TICK_CYCLES(4)) dut (
    .clk(clk), .reset_n(reset_n), .softReset(softReset),
    .hostAddr(hostAddr), .hostRead(hostRead), .hostWrite(hostWrite),
    .hostWrData(hostWrData), .hostRdData(hostRdData), .irq(irq),
    .frameBitErrCnt(cnt[0]), .crc6ErrCnt(cnt[1]),
    .outOfFrameCnt(cnt[2]), .alignChangeCnt(cnt[3]),
    .bipolarViolCnt(cnt[4]), .testPatternErrCnt(cnt[5]),
    .testPatternMfCnt(cnt[6]), .mfOutOfSyncCnt(cnt[7]),
    .terminalSync(ev[0]), .multiframeSync(ev[1]),
    .framingBitTick(ev[2]), .framingBitError(ev[3]),
    .alignmentChange(ev[4]), .allOnesAlarm(ev[5]),
    .crc6Error(ev[6]), .signalLoss(ev[7]),
    .superframeYellow(ev[8]), .secondaryYellow(ev[9]),
    .extSuperframeYellow(ev[10]), .dataModeYellow(ev[11])
  );

  // ------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------
  task automatic complete_run;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : complete_run

  task automatic check(input string what, input logic [15:0] seen,
                       input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic wr(input logic [11:0] a, input logic [15:0] d);
    @(posedge clk);
    hostAddr   <= a;
    hostWrData <= d;
    hostWrite  <= 1'b1;
    @(posedge clk);
    hostWrite  <= 1'b0;
  endtask : wr

  task automatic rd(input logic [11:0] a, input logic [15:0] exp);
    @(posedge clk);
    hostAddr <= a;
    hostRead <= 1'b1;
    @(posedge clk);
    hostRead <= 1'b0;
    #1;
    check($sformatf("reg %h", a), hostRdData, exp);
  endtask : rd

  task automatic pulse(input int k, input logic [1:0] v);
    @(posedge clk);
    ev[k] <= v;
    @(posedge clk);
    ev[k] <= 2'h0;
  endtask : pulse

  task automatic fbit(input logic err);
    @(posedge clk);
    ev[2] <= 2'h1;
    ev[3] <= {1'b0, err};
    @(posedge clk);
    ev[2] <= 2'h0;
    ev[3] <= 2'h0;
  endtask : fbit

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic counter_wraps;
    logic [11:0] ofs;
    wr(12'h844, 16'hFFFF);
    rd(12'h144, 16'hFFFF);
    for (int i = 0; i < 8; i++) begin
      @(posedge clk);
      cnt[i][7:0] <= 8'hFF;
      @(posedge clk);
      cnt[i][7:0] <= 8'h00;
      ofs = (i % 2) ? 12'h024 : 12'h034;
      rd(ofs, 16'h8000 >> i);
      rd(ofs ^ 12'h010, 16'h0000);
    end
    wr(12'h044, 16'hFDFF);
    @(posedge clk);
    cnt[6][7:0] <= 8'hFF;
    @(posedge clk);
    cnt[6][7:0] <= 8'h00;
    rd(12'h034, 16'h0000);
    wr(12'h044, 16'hFFFF);
  endtask : counter_wraps

  task automatic line_events;
    int idx [5] = '{1, 4, 5, 6, 7};
    int bitn [5] = '{6, 4, 2, 1, 0};
    for (int j = 0; j < 5; j++) begin
      pulse(idx[j], 2'h1);
      @(posedge clk);
      #1;
      check("irq", {15'h0000, irq}, 16'h0001);
      rd(12'h034, 16'h0001 << bitn[j]);
      repeat (2) @(posedge clk);
      #1;
      check("irq", {15'h0000, irq}, 16'h0000);
    end
    pulse(7, 2'h2);
    rd(12'h034, 16'h0000);
    rd(12'h834, 16'h0000);
    rd(12'h134, 16'h0001);
    wr(12'h044, 16'h0000);
    pulse(7, 2'h1);
    repeat (2) @(posedge clk);
    #1;
    check("irq", {15'h0000, irq}, 16'h0000);
    rd(12'h034, 16'h0000);
    wr(12'h844, 16'hFFFF);
  endtask : line_events

  task automatic framing_errors;
    @(posedge clk);
    ev[0] <= 2'h1;
    rd(12'h034, 16'h0080);
    fbit(1'b1);
    rd(12'h034, 16'h0020);
    fbit(1'b0);
    fbit(1'b1);
    rd(12'h034, 16'h0028);
    repeat (5) fbit(1'b0);
    fbit(1'b1);
    rd(12'h034, 16'h0020);
    @(posedge clk);
    ev[0] <= 2'h0;
    rd(12'h034, 16'h0080);
    fbit(1'b1);
    rd(12'h034, 16'h0008);
  endtask : framing_errors

  task automatic yellow_alarms;
    wr(12'h045, 16'hFFFF);
    rd(12'h045, 16'hF800);
    for (int j = 0; j < 3; j++) begin
      pulse(9 + j, 2'h1);
      rd(12'h035, 16'h2000 >> j);
      rd(12'h025, 16'h0000);
    end
    @(posedge clk);
    ev[8] <= 2'h1;
    repeat (170) @(posedge clk);
    rd(12'h035, 16'h8000);
    repeat (40) @(posedge clk);
    rd(12'h025, 16'hC000);
    @(posedge clk);
    ev[8] <= 2'h0;
    rd(12'h035, 16'h8000);
    rd(12'h035, 16'h0000);
    wr(12'h035, 16'hFFFF);
    rd(12'h035, 16'h0000);
  endtask : yellow_alarms

  task automatic soft_reset_clears;
    pulse(7, 2'h1);
    @(posedge clk);
    softReset <= 1'b1;
    @(posedge clk);
    softReset <= 1'b0;
    rd(12'h034, 16'h0000);
    rd(12'h044, 16'h0000);
  endtask : soft_reset_clears

  // ------------------------------------------------------------
  // Main sequence and watchdog
  // ------------------------------------------------------------
  initial begin
    repeat (20) @(posedge clk);
    reset_n <= 1'b1;
    rd(12'h034, 16'h0000);
    rd(12'h035, 16'h0000);
    counter_wraps();
    line_events();
    framing_errors();
    yellow_alarms();
    soft_reset_clears();
    complete_run();
  end

  initial begin
    #200us;
    mismatches++;
    complete_run();
  end
endmodule : t1_sync_alarm_irq_status_bench

`default_nettype wire
